// File: hw/pin_routing_pkg.sv
package pin_routing_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_PINS     = 36;
  localparam int NUM_INPUTS   = 8;
  localparam int NUM_SOURCES  = 64;
  localparam int SEL_W        = 6;
  localparam int DATA_W       = 8;
  localparam int ADDR_W       = 6;
  // ==========================================================
  // pin codes: port times eight plus bit
  localparam logic [SEL_W-1:0] PIN_CODE_MAX = 6'h23;
  localparam logic [SEL_W-1:0] SRC_LATCH    = 6'h00;
  // i2c capable pins
  localparam logic [SEL_W-1:0] PIN_I2C_0 = 6'h09;
  localparam logic [SEL_W-1:0] PIN_I2C_1 = 6'h0A;
  localparam logic [SEL_W-1:0] PIN_I2C_2 = 6'h13;
  localparam logic [SEL_W-1:0] PIN_I2C_3 = 6'h14;
  // ==========================================================
  // unlock keys
  localparam logic [DATA_W-1:0] KEY_FIRST  = 8'h55;
  localparam logic [DATA_W-1:0] KEY_SECOND = 8'hAA;
  localparam int LOCK_BIT = 0;
  // default input pins after power-on
  localparam logic [NUM_INPUTS*SEL_W-1:0] IN_DEFAULT =
    {6'h0C, 6'h17, 6'h16, 6'h14, 6'h13, 6'h10, 6'h04, 6'h08};
  typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_OPEN} unlock_t;
endpackage

// File: hw/sel_bus_if.sv
`timescale 1ns/10ps
interface sel_bus_if;
  logic                                   we;
  logic [pin_routing_pkg::ADDR_W-1:0]     addr;
  logic [pin_routing_pkg::SEL_W-1:0]      wdata;
  logic [pin_routing_pkg::SEL_W-1:0]      rdata;
  modport master (output we, output addr, output wdata, input rdata);
  modport slave  (input we, input addr, input wdata, output rdata);
endinterface

// File: hw/sel_store.sv
`timescale 1ns/10ps
module sel_store
(
  input  wire logic clock,           // system clock
  input  wire logic nrst_por,        // power-on reset, active low
  sel_bus_if.slave  bus,             // write/read port
  output logic [pin_routing_pkg::NUM_PINS*pin_routing_pkg::SEL_W-1:0]
                    out_sel_flat     // all pin source selections
);
  typedef struct packed {
    logic [pin_routing_pkg::NUM_PINS-1:0][pin_routing_pkg::SEL_W-1:0] sel;
    logic [pin_routing_pkg::SEL_W-1:0]                                rd;
  } store_t;
  store_t st;
  store_t next_st;
  logic   in_range;
  // ==========================================================
  // pins above the last one neither store nor read back
  assign in_range =
    bus.addr < pin_routing_pkg::ADDR_W'(pin_routing_pkg::NUM_PINS);
  // ==========================================================
  // one source register per pin, same encoding each
  always_comb
  begin
    next_st = st;
    if (bus.we && in_range)
      next_st.sel[bus.addr] = bus.wdata;
    if (in_range)
      next_st.rd = st.sel[bus.addr];
    else
      next_st.rd = '0;
  end
  // only power-on clears; sleep has no path here
  always_ff @(posedge clock or negedge nrst_por)
  begin
    if (!nrst_por)
      st <= '0;
    else
      st <= next_st;
  end
  assign bus.rdata    = st.rd;
  assign out_sel_flat = st.sel;
endmodule

// File: hw/peripheral_pin_routing.sv
`timescale 1ns/10ps
module peripheral_pin_routing
(
  input  wire logic                clock,              // system clock
  input  wire logic                nrst,               // any reset, low
  input  wire logic                nrst_por,           // power-on, low
  input  wire logic                one_time_lock_option, // config bit
  input  wire logic                sleep_mode,         // device asleep
  // software access
  input  wire logic                cpu_access,         // any sfr access
  input  wire logic                lock_we,            // write lock reg
  input  wire logic [7:0]          lock_wdata,         // lock write data
  input  wire logic                in_sel_we,          // write input sel
  input  wire logic [2:0]          in_sel_idx,         // input index
  input  wire logic                out_sel_we,         // write pin sel
  input  wire logic [5:0]          out_sel_idx,        // pin index
  input  wire logic [5:0]          sel_wdata,          // select value
  output logic [5:0]               in_sel_rdata,       // input sel read
  output logic [5:0]               out_sel_rdata,      // pin sel read
  output logic                     selections_locked_flag, // lock state
  // pins and peripherals
  input  wire logic [35:0]         pin_in,             // raw pin levels
  input  wire logic [35:0]         i2c_level_in,       // i2c buffer level
  input  wire logic [35:0]         input_threshold_select, // 1 st
  input  wire logic [35:0]         ttl_level_in,       // ttl buffer level
  input  wire logic [35:0]         port_output_latch,  // latch bits
  input  wire logic [35:0]         pin_direction_ctrl, // 1 input
  input  wire logic [63:0]         periph_out,         // source levels
  input  wire logic [63:0]         periph_oe_override, // take driver
  input  wire logic [63:0]         periph_oe,          // when override
  input  wire logic [7:0]          input_is_i2c,       // i2c input
  output logic [7:0]               periph_in,          // routed inputs
  output logic [35:0]              pin_out,            // pin out level
  output logic [35:0]              pin_oe              // driver enable
);
  typedef struct packed {
    logic [pin_routing_pkg::NUM_INPUTS-1:0][pin_routing_pkg::SEL_W-1:0]
                                    in_sel;
    logic [pin_routing_pkg::NUM_PINS-1:0] sync1;
    logic [pin_routing_pkg::NUM_PINS-1:0] sync2;
    logic [pin_routing_pkg::NUM_PINS-1:0] i2c1;
    logic [pin_routing_pkg::NUM_PINS-1:0] i2c2;
    logic [pin_routing_pkg::NUM_PINS-1:0] ttl1;
    logic [pin_routing_pkg::NUM_PINS-1:0] ttl2;
    logic [pin_routing_pkg::NUM_INPUTS-1:0] pin_in_r;
    logic [pin_routing_pkg::NUM_PINS-1:0] pout;
    logic [pin_routing_pkg::NUM_PINS-1:0] poe;
    logic [pin_routing_pkg::SEL_W-1:0]    in_rd;
  } route_t;
  typedef struct packed {
    pin_routing_pkg::unlock_t ul;
    logic                     locked;
    logic                     cleared_once;
    logic                     set_once;
  } lock_t;

  route_t rt;
  route_t next_rt;
  lock_t  lk;
  lock_t  next_lk;
  logic [pin_routing_pkg::NUM_PINS*pin_routing_pkg::SEL_W-1:0] out_flat;
  logic [pin_routing_pkg::NUM_PINS-1:0][pin_routing_pkg::SEL_W-1:0] out_sel;
  logic [pin_routing_pkg::NUM_PINS-1:0] i2c_pin;

  // ==========================================================
  // decode helper: does this pin code carry an i2c buffer
  function automatic logic is_i2c_pin(input logic [5:0] code);
    is_i2c_pin = (code == pin_routing_pkg::PIN_I2C_0) ||
                 (code == pin_routing_pkg::PIN_I2C_1) ||
                 (code == pin_routing_pkg::PIN_I2C_2) ||
                 (code == pin_routing_pkg::PIN_I2C_3);
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < pin_routing_pkg::NUM_PINS; gp++)
    begin : g_pin
      assign i2c_pin[gp] = is_i2c_pin(6'(gp));
    end
  endgenerate

  // ==========================================================
  // output selection store
  sel_bus_if sbus ();
  assign sbus.we    = out_sel_we && !lk.locked;
  assign sbus.addr  = out_sel_idx;
  assign sbus.wdata = sel_wdata;
  sel_store u_store
  (
    .clock        (clock),
    .nrst_por     (nrst_por),
    .bus          (sbus.slave),
    .out_sel_flat (out_flat)
  );
  assign out_sel = out_flat;

  // ==========================================================
  // lock sequencer; any other access between keys aborts
  always_comb
  begin
    next_lk = lk;
    case (lk.ul)
      pin_routing_pkg::UL_IDLE:
        if (lock_we && lock_wdata == pin_routing_pkg::KEY_FIRST)
          next_lk.ul = pin_routing_pkg::UL_GOT_FIRST;
      pin_routing_pkg::UL_GOT_FIRST:
        if (lock_we && lock_wdata == pin_routing_pkg::KEY_SECOND)
          next_lk.ul = pin_routing_pkg::UL_OPEN;
        else if (cpu_access || lock_we)
          next_lk.ul = pin_routing_pkg::UL_IDLE;
      pin_routing_pkg::UL_OPEN:
        if (lock_we)
        begin
          next_lk.ul = pin_routing_pkg::UL_IDLE;
          if (lock_wdata[pin_routing_pkg::LOCK_BIT] && !lk.locked)
          begin
            if (!one_time_lock_option || !lk.set_once)
            begin
              next_lk.locked   = 1'b1;
              next_lk.set_once = 1'b1;
            end
          end
          else if (!lock_wdata[pin_routing_pkg::LOCK_BIT] && lk.locked)
          begin
            // one-time option: no clear, since a lock is only ever set with set_once
            if (!one_time_lock_option ||
                (!lk.cleared_once && !lk.set_once))
            begin
              next_lk.locked       = 1'b0;
              next_lk.cleared_once = 1'b1;
            end
          end
        end
        else if (cpu_access)
          next_lk.ul = pin_routing_pkg::UL_IDLE;
      default:
        next_lk.ul = pin_routing_pkg::UL_IDLE;
    endcase
  end

  // any device reset restarts the one-time allowance
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      lk <= '{pin_routing_pkg::UL_IDLE, 1'b0, 1'b0, 1'b0};
    else
      lk <= next_lk;
  end

  // ==========================================================
  // routing datapath
  always_comb
  begin
    next_rt = rt;
    next_rt.sync1 = pin_in;
    next_rt.sync2 = rt.sync1;
    next_rt.i2c1  = i2c_level_in;
    next_rt.i2c2  = rt.i2c1;
    next_rt.ttl1  = ttl_level_in;
    next_rt.ttl2  = rt.ttl1;
    if (in_sel_we && !lk.locked)
      next_rt.in_sel[in_sel_idx] = sel_wdata;
    next_rt.in_rd = rt.in_sel[in_sel_idx];
    for (int i = 0; i < pin_routing_pkg::NUM_INPUTS; i++)
    begin
      // bad codes read low; software keeps to the pins it supports
      if (rt.in_sel[i] > pin_routing_pkg::PIN_CODE_MAX)
        next_rt.pin_in_r[i] = 1'b0;
      else if (input_is_i2c[i] && i2c_pin[rt.in_sel[i]])
        next_rt.pin_in_r[i] = rt.i2c2[rt.in_sel[i]];
      else if (input_threshold_select[rt.in_sel[i]])
        next_rt.pin_in_r[i] = rt.sync2[rt.in_sel[i]];
      else
        next_rt.pin_in_r[i] = rt.ttl2[rt.in_sel[i]];
    end
    for (int p = 0; p < pin_routing_pkg::NUM_PINS; p++)
    begin
      if (out_sel[p] == pin_routing_pkg::SRC_LATCH)
        next_rt.pout[p] = port_output_latch[p];
      else
        next_rt.pout[p] = periph_out[out_sel[p]];
      // sync serial / i2c may take the driver; same-pin pairing
      if (out_sel[p] != pin_routing_pkg::SRC_LATCH &&
          periph_oe_override[out_sel[p]])
        next_rt.poe[p] = periph_oe[out_sel[p]];
      else
        next_rt.poe[p] = !pin_direction_ctrl[p];
    end
  end

  // input selections reload IN_DEFAULT only at power-on; sleep_mode has no effect
  always_ff @(posedge clock or negedge nrst_por)
  begin
    if (!nrst_por)
    begin
      rt        <= '0;
      rt.in_sel <= pin_routing_pkg::IN_DEFAULT;
    end
    else
      rt <= next_rt;
  end

  assign periph_in              = rt.pin_in_r;
  assign pin_out                = rt.pout;
  assign pin_oe                 = rt.poe;
  assign in_sel_rdata           = rt.in_rd;
  assign out_sel_rdata          = sbus.rdata;
  assign selections_locked_flag = lk.locked;
endmodule

// File: tb/pin_routing_properties.sv
`timescale 1ns/10ps
// ==========================================================
// routing checker
module pin_routing_properties
(
  input wire logic        clock,                  // clock
  input wire logic        nrst,                   // any reset
  input wire logic        nrst_por,               // power-on
  input wire logic        one_time_lock_option,   // config
  input wire logic        lock_we,                // lock write
  input wire logic [7:0]  lock_wdata,             // lock data
  input wire logic [2:0]  in_sel_idx,             // input index
  input wire logic        out_sel_we,             // pin write
  input wire logic [5:0]  out_sel_idx,            // pin index
  input wire logic [5:0]  in_sel_rdata,           // input read
  input wire logic [5:0]  out_sel_rdata,          // pin read
  input wire logic        selections_locked_flag, // lock state
  input wire logic [35:0] port_output_latch,      // latch
  input wire logic [35:0] pin_direction_ctrl,     // 1 input
  input wire logic [63:0] periph_oe_override,     // take driver
  input wire logic [63:0] periph_oe,              // source oe
  input wire logic [35:0] pin_out,                // pin level
  input wire logic [35:0] pin_oe                  // driver on
);
  logic [5:0]  idx_q;
  logic        we_q;
  logic        por_q;
  logic [35:0] lat_q;
  logic [35:0] dir_q;
  logic [63:0] ovr_q;
  logic [63:0] poe_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !nrst_por);
  // inputs one cycle back, aligned with the read-back
  always_ff @(posedge clock)
  begin
    idx_q <= out_sel_idx;
    we_q  <= out_sel_we;
    por_q <= nrst_por;
    lat_q <= port_output_latch;
    dir_q <= pin_direction_ctrl;
    ovr_q <= periph_oe_override;
    poe_q <= periph_oe;
  end
  sequence s_keyed;
    lock_we && lock_wdata == 8'h55 ##1 lock_we && lock_wdata == 8'hAA
    ##1 lock_we;
  endsequence
  sequence s_pin_seen;
    por_q && !we_q && idx_q < 6'd36;
  endsequence
  property p_key_apply;
    s_keyed ##0 !one_time_lock_option |=>
      selections_locked_flag == $past(lock_wdata[0]);
  endproperty
  property p_change_keyed;
    $changed(selections_locked_flag) |->
      $past(lock_we) && selections_locked_flag == $past(lock_wdata[0]);
  endproperty
  property p_one_way;
    one_time_lock_option && selections_locked_flag |=>
      selections_locked_flag;
  endproperty
  property p_out_frozen;
    $past(selections_locked_flag) && $stable(out_sel_idx) |=>
      $stable(out_sel_rdata);
  endproperty
  property p_in_frozen;
    $past(selections_locked_flag) && $stable(in_sel_idx) |=>
      $stable(in_sel_rdata);
  endproperty
  property p_latch_src;
    s_pin_seen ##0 out_sel_rdata == 6'h00 |-> pin_out[idx_q] == lat_q[idx_q];
  endproperty
  property p_dir_keeps;
    s_pin_seen ##0 (out_sel_rdata == 6'h00 || !ovr_q[out_sel_rdata]) |->
      pin_oe[idx_q] == !dir_q[idx_q];
  endproperty
  property p_override;
    s_pin_seen ##0 (out_sel_rdata != 6'h00 && ovr_q[out_sel_rdata]) |->
      pin_oe[idx_q] == poe_q[out_sel_rdata];
  endproperty
  property p_idx_range;
    out_sel_idx > 6'd35 |=> out_sel_rdata == 6'h00;
  endproperty
  a_key_apply: assert property (p_key_apply)
    else $error("lock change after keys wrong");
  a_change_keyed: assert property (p_change_keyed)
    else $error("lock flag changed without a lock write");
  a_one_way: assert property (p_one_way)
    else $error("one-time lock was cleared");
  a_out_frozen: assert property (p_out_frozen)
    else $error("pin selection changed while locked");
  a_in_frozen: assert property (p_in_frozen)
    else $error("input selection changed while locked");
  a_latch_src: assert property (p_latch_src)
    else $error("source zero does not follow latch");
  a_dir_keeps: assert property (p_dir_keeps)
    else $error("driver enable not from direction");
  a_override: assert property (p_override)
    else $error("peripheral override not applied");
  a_idx_range: assert property (p_idx_range)
    else $error("absent pin reads non-zero");
endmodule
bind peripheral_pin_routing pin_routing_properties u_props (.*);

// File: tb/pin_world_model.sv
`timescale 1ns/10ps
// ==========================================================
// pin wires and board drive beyond the router
module pin_world_model
(
  input  wire logic [35:0] pin_out,      // router level
  input  wire logic [35:0] pin_oe,       // router drives
  input  wire logic [35:0] ext_level,    // board level
  input  wire logic [35:0] skew_i2c,     // i2c buffer flip
  input  wire logic [35:0] skew_ttl,     // ttl buffer flip
  output logic      [35:0] pin_in,       // st view
  output logic      [35:0] i2c_level_in, // i2c view
  output logic      [35:0] ttl_level_in  // ttl view
);
  // a driven pin reads back its own drive, so a shared pin works
  assign pin_in       = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // skews let a test tell which buffer was used
  assign i2c_level_in = pin_in ^ skew_i2c;
  assign ttl_level_in = pin_in ^ skew_ttl;
endmodule

// File: tb/tb_peripheral_pin_routing.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h seen %0h", n, e, g); end end
// ==========================================================
// bench
module tb_peripheral_pin_routing;
  logic        clock, nrst, nrst_por, one_time_lock_option, sleep_mode;
  logic        cpu_access, lock_we, in_sel_we, out_sel_we;
  logic        selections_locked_flag;
  logic [7:0]  lock_wdata, input_is_i2c, periph_in;
  logic [2:0]  in_sel_idx;
  logic [5:0]  out_sel_idx, sel_wdata, in_sel_rdata, out_sel_rdata, v;
  logic [35:0] pin_in, i2c_level_in, input_threshold_select, ttl_level_in;
  logic [35:0] port_output_latch, pin_direction_ctrl, pin_out, pin_oe;
  logic [35:0] ext_level, skew_i2c, skew_ttl;
  logic [63:0] periph_out, periph_oe_override, periph_oe;
  // each code lies inside the pins its input supports
  logic [5:0]  codes [4] = '{6'h00, 6'h08, 6'h11, 6'h0F};
  logic [2:0]  ins [4]   = '{3'h0, 3'h0, 3'h6, 3'h0};
  // shared test pin, supported by the serial clock functions
  localparam logic [5:0] PB = 6'h16;
  logic [5:0]  in_def [8] = '{6'h08, 6'h04, 6'h10, 6'h13, 6'h14, 6'h16,
                              6'h17, 6'h0C};
  int          n_fail, comparisons, cycles;
  peripheral_pin_routing u_dut (.*);
  pin_world_model u_world (.*);
  always #5 clock = ~clock;
  // hang guard, far above the under two hundred cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task end_of_test;
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one selection write, input side or pin side
  task sel_wr(input bit out, input logic [5:0] i, input logic [5:0] d);
    @(posedge clock);
    out_sel_we <= out;
    in_sel_we <= !out;
    out_sel_idx <= i;
    in_sel_idx <= i[2:0];
    sel_wdata <= d;
    @(posedge clock);
    out_sel_we <= 1'b0;
    in_sel_we <= 1'b0;
  endtask
  task sel_chk(input bit out, input logic [5:0] i, input logic [5:0] e);
    @(posedge clock);
    out_sel_idx <= i;
    in_sel_idx <= i[2:0];
    tick(2);
    v = out ? out_sel_rdata : in_sel_rdata;
    `CHK("selection", e, v)
  endtask
  // key, key, value on back-to-back cycles; brk slips in another access
  task lock_seq(input logic [7:0] k, input logic [7:0] d, input bit brk,
                input logic e);
    @(posedge clock);
    lock_we <= 1'b1;
    lock_wdata <= 8'h55;
    if (brk)
    begin
      @(posedge clock);
      lock_we <= 1'b0;
      cpu_access <= 1'b1;
    end
    @(posedge clock);
    lock_we <= 1'b1;
    cpu_access <= 1'b0;
    lock_wdata <= k;
    @(posedge clock);
    lock_wdata <= d;
    @(posedge clock);
    lock_we <= 1'b0;
    @(posedge clock);
    `CHK("lock flag", e, selections_locked_flag)
  endtask
  initial
  begin
    {clock, nrst, nrst_por, one_time_lock_option, sleep_mode} = '0;
    {cpu_access, lock_we, in_sel_we, out_sel_we, lock_wdata} = '0;
    {input_is_i2c, in_sel_idx, out_sel_idx, sel_wdata} = '0;
    {port_output_latch, ext_level, skew_i2c, skew_ttl} = '0;
    {periph_out, periph_oe_override, periph_oe} = '0;
    input_threshold_select = '1;
    pin_direction_ctrl = '1;
    {n_fail, comparisons, cycles} = '0;
    tick(12);
    nrst <= 1'b1;
    nrst_por <= 1'b1;
    for (int j = 0; j < 8; j++)
      sel_chk(0, 6'(j), in_def[j]);
    foreach (codes[k])
    begin
      sel_wr(0, 6'(ins[k]), codes[k]);
      ext_level <= 36'h1 << codes[k];
      tick(5);
      `CHK("routed input", 1'b1, periph_in[ins[k]])
    end
    // i2c input on a dedicated pin, then on a plain ttl pin
    input_is_i2c <= 8'h08;
    skew_i2c <= '1;
    sel_wr(0, 3, 6'h13);
    ext_level <= 36'h1 << 19;
    tick(5);
    `CHK("i2c buffer", 1'b0, periph_in[3])
    sel_wr(0, 3, PB);
    ext_level <= 36'h1 << PB;
    input_threshold_select <= ~(36'h1 << PB);
    // only the ttl view is flipped, so st or i2c would read high
    skew_i2c <= '0;
    skew_ttl <= 36'h1 << PB;
    tick(5);
    `CHK("plain buffer", 1'b0, periph_in[3])
    // test pin from its latch, then from source 0x10 sharing the pin
    pin_direction_ctrl <= ~(36'h1 << PB);
    port_output_latch <= 36'h1 << PB;
    ext_level <= '0;
    input_threshold_select <= '1;
    skew_ttl <= '0;
    sel_chk(1, PB, 6'h00);
    `CHK("latch drive", 1'b1, pin_out[PB])
    `CHK("direction oe", 1'b1, pin_oe[PB])
    sel_wr(1, PB, 6'h10);
    periph_out <= 64'h1 << 16;
    periph_oe_override <= 64'h1 << 16;
    periph_oe <= 64'h1 << 16;
    pin_direction_ctrl <= '1;
    sel_wr(0, 5, PB);
    tick(5);
    `CHK("source drive", 1'b1, pin_out[PB])
    `CHK("override oe", 1'b1, pin_oe[PB])
    `CHK("shared pin", 1'b1, periph_in[5])
    periph_oe_override <= '0;
    tick(3);
    `CHK("direction oe", 1'b0, pin_oe[PB])
    lock_seq(8'hAA, 8'h01, 0, 1);
    sel_wr(1, PB, 6'h00);
    sel_chk(1, PB, 6'h10);
    sel_wr(0, 0, 6'h01);
    sel_chk(0, 0, 6'h0F);
    lock_seq(8'hAA, 8'h00, 1, 1);
    lock_seq(8'h5A, 8'h00, 0, 1);
    sleep_mode <= 1'b1;
    lock_seq(8'hAA, 8'h00, 0, 0);
    sel_chk(1, PB, 6'h10);
    sel_chk(1, 40, 6'h00);
    sleep_mode <= 1'b0;
    lock_seq(8'hAA, 8'h01, 0, 1);
    // plain reset keeps selections
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    one_time_lock_option <= 1'b1;
    sel_chk(1, PB, 6'h10);
    lock_seq(8'hAA, 8'h00, 0, 0);
    lock_seq(8'hAA, 8'h01, 0, 1);
    lock_seq(8'hAA, 8'h00, 0, 1);
    nrst <= 1'b0;
    nrst_por <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    nrst_por <= 1'b1;
    sel_chk(1, PB, 6'h00);
    sel_chk(0, 0, 6'h08);
    end_of_test();
  end
endmodule
